// ### hdl/dtc_pkg.sv
// package for the drive terminal command logic: input positions,
// configuration carrier, reset values and timing counts.
// assumes a single 10 MHz system clock shared by every user of it.
package dtc_pkg;

    // data width of speed, ramp and torque words
    localparam int DTC_W = 16;

    // positions of the eight terminal inputs in the input vector
    localparam int DI_JOG_ONE = 0;
    localparam int DI_JOG_TWO = 1;
    localparam int DI_EXT_FAULT = 2;
    localparam int DI_EXT_ALARM = 3;
    localparam int DI_ESTOP = 4;
    localparam int DI_FAULT_ACK = 5;
    localparam int DI_ON_OFF = 6;
    localparam int DI_RUN = 7;
    localparam int NUM_DI = 8;

    // reset value of the debounced levels: all low, so estop reads open
    localparam logic [NUM_DI-1:0] DI_RST_LEVELS = 8'h00;

    // full torque limit (100.00 % in units of 0.01 %)
    localparam logic [DTC_W-1:0] FULL_TORQUE = 16'h2710;
    localparam logic [DTC_W-1:0] SPEED_ZERO = 16'h0000;

    // input settling time and its count of clock cycles
    localparam int CLK_PERIOD_NS = 100;
    localparam int DEBOUNCE_US = 1000;
    localparam int DEBOUNCE_CYCLES = (DEBOUNCE_US * 1000 + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int DEB_CNT_W = 16;

    // static configuration set during commissioning
    typedef struct packed {
        logic hand_auto_sel;                  // hand/auto terminal layout
        logic limited_speed_control;          // torque limit from analog 2
        logic [DTC_W-1:0] jog_one_speed;
        logic [DTC_W-1:0] jog_two_speed;
        logic [DTC_W-1:0] accel_ramp;
        logic [DTC_W-1:0] decel_ramp;
        logic [DTC_W-1:0] jog_accel_ramp;
        logic [DTC_W-1:0] jog_decel_ramp;
        logic [DTC_W-1:0] zero_speed_lev;     // standstill band, magnitude
    } dtc_cfg_t;

endpackage

// ### hdl/dtc_debounce.sv
// three-stage synchroniser and settling filter for terminal inputs.
// assumes pins change at will with respect to i_clock.
`timescale 1ns/100ps

module dtc_debounce #(
    parameter int N = 8,
    parameter int CW = 16,
    parameter int DEB_CYCLES = 10000
)
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // raw pins
    input wire logic [N-1:0] i_pins,
    // settled levels
    output logic [N-1:0] o_levels
);

    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
        logic [N-1:0] s3;
        logic [N-1:0] level;
        logic [N-1:0][CW-1:0] cnt;
    } dtc_deb_state_t;

    dtc_deb_state_t st_q;
    dtc_deb_state_t st_d;

    // refuse a settling count the counter cannot hold
    if (DEB_CYCLES < 1 || DEB_CYCLES >= (2 ** CW))
    begin : g_bad_count
        $error("dtc_debounce: DEB_CYCLES out of counter range");
    end

    // a change counts only when stages two and three agree, and then only
    // after it has held for the full settling count
    always_comb
    begin
        st_d = st_q;
        st_d.s1 = i_pins;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < N; i++)
        begin
            if (st_q.s2[i] == st_q.s3[i] && st_q.s3[i] != st_q.level[i])
            begin
                if (st_q.cnt[i] == CW'(DEB_CYCLES - 1))
                begin
                    st_d.level[i] = st_q.s3[i];
                    st_d.cnt[i] = '0;
                end
                else
                begin
                    st_d.cnt[i] = st_q.cnt[i] + 1'b1;
                end
            end
            else
            begin
                st_d.cnt[i] = '0;  // bounce restarts the wait
            end
        end
    end

    // state register
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign o_levels = st_q.level;

    // a settled level only ever moves to the value stage three held
    property p_settle;
        @(posedge i_clock) disable iff (i_rst)
        (st_q.level != $past(st_q.level)) |->
            ((st_q.level ^ $past(st_q.level)) & ~($past(st_q.s3) ^ st_q.level))
            == (st_q.level ^ $past(st_q.level));
    endproperty
    a_settle: assert property (p_settle)
        else $error("settled level moved without agreeing stages");

endmodule // dtc_debounce

// ### hdl/dtc_command.sv
// terminal command logic of the dc drive, standard terminal layout with
// an optional hand/auto layout. decodes the eight digital inputs, resolves
// the jog/start interlock and drives the five status outputs.
// assumes pins are asynchronous and the configuration is static.
`timescale 1ns/100ps

module dtc_command #(
    parameter int DEB_CYCLES = dtc_pkg::DEBOUNCE_CYCLES
)
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // terminal inputs
    input wire logic i_jog_one_in,
    input wire logic i_jog_two_in,
    input wire logic i_ext_fault_in,
    input wire logic i_ext_alarm_in,
    input wire logic i_estop_loop_in,
    input wire logic i_fault_ack_in,
    input wire logic i_on_off_in,
    input wire logic i_run_in,
    // analog values and configuration
    input wire logic [dtc_pkg::DTC_W-1:0] i_speed_ref_analog,
    input wire logic [dtc_pkg::DTC_W-1:0] i_torque_lim_analog,
    input wire logic signed [dtc_pkg::DTC_W-1:0] i_speed_actual,
    input wire dtc_pkg::dtc_cfg_t i_cfg,
    // terminal outputs
    output logic o_ready_for_run_out,
    output logic o_running_out,
    output logic o_zero_speed_out,
    output logic o_group_fault_out,
    output logic o_main_contactor_out,
    // towards ramp and regulator
    output logic o_current_ctrl_en,
    output logic [dtc_pkg::DTC_W-1:0] o_speed_ref,
    output logic [dtc_pkg::DTC_W-1:0] o_accel_ramp,
    output logic [dtc_pkg::DTC_W-1:0] o_decel_ramp,
    output logic [dtc_pkg::DTC_W-1:0] o_torque_limit,
    output logic o_jog_active,
    output logic o_fault_active,
    output logic o_alarm_active,
    output logic [dtc_pkg::DTC_W-1:0] o_speed_actual_analog_out
);

    typedef struct packed {
        logic ack_prev;
        logic fault;
        logic alarm;
        logic ready;
        logic running;
        logic zero;
        logic group;
        logic contactor;
        logic jog;
        logic [dtc_pkg::DTC_W-1:0] speed_ref;
        logic [dtc_pkg::DTC_W-1:0] accel;
        logic [dtc_pkg::DTC_W-1:0] decel;
        logic [dtc_pkg::DTC_W-1:0] torque;
        logic [dtc_pkg::DTC_W-1:0] speed_act;
    } dtc_state_t;

    dtc_state_t st_q;
    dtc_state_t st_d;
    logic [dtc_pkg::NUM_DI-1:0] pins;
    logic [dtc_pkg::NUM_DI-1:0] db;

    // magnitude of a signed speed word
    function automatic logic [dtc_pkg::DTC_W-1:0] speed_mag(
        input logic signed [dtc_pkg::DTC_W-1:0] v);
        speed_mag = v[dtc_pkg::DTC_W-1] ? dtc_pkg::DTC_W'(-v) : v;
    endfunction

    // gather the pins into one vector for the filter
    always_comb
    begin
        pins = '0;
        pins[dtc_pkg::DI_JOG_ONE] = i_jog_one_in;
        pins[dtc_pkg::DI_JOG_TWO] = i_jog_two_in;
        pins[dtc_pkg::DI_EXT_FAULT] = i_ext_fault_in;
        pins[dtc_pkg::DI_EXT_ALARM] = i_ext_alarm_in;
        pins[dtc_pkg::DI_ESTOP] = i_estop_loop_in;
        pins[dtc_pkg::DI_FAULT_ACK] = i_fault_ack_in;
        pins[dtc_pkg::DI_ON_OFF] = i_on_off_in;
        pins[dtc_pkg::DI_RUN] = i_run_in;
    end

    // no command logic sees a raw pin
    dtc_debounce #(
        .N(dtc_pkg::NUM_DI),
        .CW(dtc_pkg::DEB_CNT_W),
        .DEB_CYCLES(DEB_CYCLES)
    ) u_debounce (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_pins(pins),
        .o_levels(db)
    );

    // command decode; the filter already costs a millisecond, so one more
    // register stage on the outputs is free and keeps them glitchless
    always_comb
    begin
        logic on_cmd;
        logic estop_ok;
        logic ack_rise;
        logic permit;
        logic start_cmd;
        logic jog;
        logic auto_sel;
        logic [dtc_pkg::DTC_W-1:0] ref_sel;
        on_cmd = db[dtc_pkg::DI_ON_OFF];
        estop_ok = db[dtc_pkg::DI_ESTOP];
        ack_rise = db[dtc_pkg::DI_FAULT_ACK] & ~st_q.ack_prev;
        auto_sel = db[dtc_pkg::DI_JOG_TWO];
        start_cmd = 1'b0;
        jog = 1'b0;
        ref_sel = dtc_pkg::SPEED_ZERO;
        permit = 1'b0;
        st_d = st_q;
        st_d.ack_prev = db[dtc_pkg::DI_FAULT_ACK];
        // a fault present at the acknowledge edge stays set
        st_d.fault = db[dtc_pkg::DI_EXT_FAULT]
            | (st_q.fault & ~ack_rise);
        st_d.alarm = db[dtc_pkg::DI_EXT_ALARM];
        if (i_cfg.hand_auto_sel)
        begin
            // hand: start on first input, ref analog one; auto: run input
            start_cmd = auto_sel ? db[dtc_pkg::DI_RUN]
                                 : db[dtc_pkg::DI_JOG_ONE];
            ref_sel = auto_sel ? i_torque_lim_analog
                               : i_speed_ref_analog;
        end
        else if (db[dtc_pkg::DI_RUN])
        begin
            start_cmd = 1'b1;
            ref_sel = i_speed_ref_analog;
        end
        else if (db[dtc_pkg::DI_JOG_TWO])
        begin
            start_cmd = 1'b1;
            jog = 1'b1;
            ref_sel = i_cfg.jog_two_speed;
        end
        else if (db[dtc_pkg::DI_JOG_ONE])
        begin
            start_cmd = 1'b1;
            jog = 1'b1;
            ref_sel = i_cfg.jog_one_speed;
        end
        // off, open loop or a latched fault all hold the drive stopped
        permit = on_cmd & estop_ok & ~st_q.fault;
        st_d.running = permit & start_cmd;
        st_d.ready = permit & ~start_cmd;
        st_d.jog = permit & start_cmd & jog;
        st_d.speed_ref = (permit & start_cmd) ? ref_sel
                                              : dtc_pkg::SPEED_ZERO;
        st_d.accel = jog ? i_cfg.jog_accel_ramp : i_cfg.accel_ramp;
        st_d.decel = jog ? i_cfg.jog_decel_ramp : i_cfg.decel_ramp;
        st_d.torque = i_cfg.limited_speed_control ? i_torque_lim_analog
                                                  : dtc_pkg::FULL_TORQUE;
        st_d.zero = speed_mag(i_speed_actual) <= i_cfg.zero_speed_lev;
        st_d.group = st_d.fault | st_d.alarm;
        st_d.contactor = on_cmd;
        st_d.speed_act = i_speed_actual;
    end

    // state register
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state register
    assign o_ready_for_run_out = st_q.ready;
    assign o_running_out = st_q.running;
    assign o_current_ctrl_en = st_q.running;
    assign o_zero_speed_out = st_q.zero;
    assign o_group_fault_out = st_q.group;
    assign o_main_contactor_out = st_q.contactor;
    assign o_speed_ref = st_q.speed_ref;
    assign o_accel_ramp = st_q.accel;
    assign o_decel_ramp = st_q.decel;
    assign o_torque_limit = st_q.torque;
    assign o_jog_active = st_q.jog;
    assign o_fault_active = st_q.fault;
    assign o_alarm_active = st_q.alarm;
    assign o_speed_actual_analog_out = st_q.speed_act;

    // checks on the command logic
    property p_on_cmd;
        @(posedge i_clock) disable iff (i_rst)
        1'b1 |=> (o_main_contactor_out == $past(db[dtc_pkg::DI_ON_OFF]));
    endproperty
    a_on_cmd: assert property (p_on_cmd)
        else $error("main contactor does not follow on command");

    property p_off_stops;
        @(posedge i_clock) disable iff (i_rst)
        !db[dtc_pkg::DI_ON_OFF] |=> !o_running_out && !o_ready_for_run_out
            && (o_speed_ref == dtc_pkg::SPEED_ZERO);
    endproperty
    a_off_stops: assert property (p_off_stops)
        else $error("drive not held stopped while off");

    property p_estop;
        @(posedge i_clock) disable iff (i_rst)
        !db[dtc_pkg::DI_ESTOP] |=> !o_running_out && !o_current_ctrl_en;
    endproperty
    a_estop: assert property (p_estop)
        else $error("drive running with estop loop open");

    property p_fault_trip;
        @(posedge i_clock) disable iff (i_rst)
        db[dtc_pkg::DI_EXT_FAULT] |=> o_fault_active && o_group_fault_out
            ##1 !o_running_out;
    endproperty
    a_fault_trip: assert property (p_fault_trip)
        else $error("external fault did not trip the drive");

    property p_alarm;
        @(posedge i_clock) disable iff (i_rst)
        db[dtc_pkg::DI_EXT_ALARM] && !st_q.fault && !db[dtc_pkg::DI_EXT_FAULT]
            |=> o_alarm_active && o_group_fault_out && !o_fault_active;
    endproperty
    a_alarm: assert property (p_alarm)
        else $error("alarm did not warn or caused a trip");

    property p_ack;
        @(posedge i_clock) disable iff (i_rst)
        o_fault_active && db[dtc_pkg::DI_FAULT_ACK] && !st_q.ack_prev
            && !db[dtc_pkg::DI_EXT_FAULT] |=> !o_fault_active;
    endproperty
    a_ack: assert property (p_ack)
        else $error("acknowledge did not clear the fault");

    // common guard for the standard layout interlock checks
    sequence s_std_ok;
        !i_cfg.hand_auto_sel && db[dtc_pkg::DI_ON_OFF]
            && db[dtc_pkg::DI_ESTOP] && !st_q.fault;
    endsequence

    property p_idle;
        @(posedge i_clock) disable iff (i_rst)
        s_std_ok and
            (!db[dtc_pkg::DI_JOG_ONE] && !db[dtc_pkg::DI_JOG_TWO]
            && !db[dtc_pkg::DI_RUN])
            |=> !o_running_out && o_ready_for_run_out;
    endproperty
    a_idle: assert property (p_idle)
        else $error("drive not stopped with no start command");

    property p_jog_one;
        @(posedge i_clock) disable iff (i_rst)
        s_std_ok and (db[dtc_pkg::DI_JOG_ONE] && !db[dtc_pkg::DI_JOG_TWO]
            && !db[dtc_pkg::DI_RUN])
            |=> o_running_out && o_jog_active
            && (o_speed_ref == $past(i_cfg.jog_one_speed))
            && (o_accel_ramp == $past(i_cfg.jog_accel_ramp));
    endproperty
    a_jog_one: assert property (p_jog_one)
        else $error("jog one not started at jog speed one");

    property p_jog_two;
        @(posedge i_clock) disable iff (i_rst)
        s_std_ok and (db[dtc_pkg::DI_JOG_TWO] && !db[dtc_pkg::DI_RUN])
            |=> o_running_out && (o_speed_ref == $past(i_cfg.jog_two_speed))
            && (o_decel_ramp == $past(i_cfg.jog_decel_ramp));
    endproperty
    a_jog_two: assert property (p_jog_two)
        else $error("jog two not started at jog speed two");

    property p_run;
        @(posedge i_clock) disable iff (i_rst)
        s_std_ok and db[dtc_pkg::DI_RUN]
            |=> o_running_out && !o_jog_active && !o_ready_for_run_out
            && (o_speed_ref == $past(i_speed_ref_analog))
            && (o_accel_ramp == $past(i_cfg.accel_ramp));
    endproperty
    a_run: assert property (p_run)
        else $error("run did not start on analog reference");

    property p_torque;
        @(posedge i_clock) disable iff (i_rst)
        1'b1 |=> o_torque_limit == ($past(i_cfg.limited_speed_control)
            ? $past(i_torque_lim_analog) : dtc_pkg::FULL_TORQUE);
    endproperty
    a_torque: assert property (p_torque)
        else $error("torque limit source wrong");

    property p_hand_auto;
        @(posedge i_clock) disable iff (i_rst)
        i_cfg.hand_auto_sel && db[dtc_pkg::DI_ON_OFF] && db[dtc_pkg::DI_ESTOP]
            && !st_q.fault && db[dtc_pkg::DI_JOG_TWO] && db[dtc_pkg::DI_RUN]
            |=> o_running_out && (o_speed_ref == $past(i_torque_lim_analog));
    endproperty
    a_hand_auto: assert property (p_hand_auto)
        else $error("auto control not started on analog two");

    property p_zero;
        @(posedge i_clock) disable iff (i_rst)
        (i_speed_actual == '0) |=> o_zero_speed_out;
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero speed not shown at standstill");

    property p_ready_run;
        @(posedge i_clock) disable iff (i_rst)
        !(o_ready_for_run_out && o_running_out)
            && (o_current_ctrl_en == o_running_out);
    endproperty
    a_ready_run: assert property (p_ready_run)
        else $error("ready and running both set");

    // main scenarios
    c_jog: cover property (@(posedge i_clock) disable iff (i_rst)
        o_jog_active ##1 !o_jog_active);
    c_run: cover property (@(posedge i_clock) disable iff (i_rst)
        o_ready_for_run_out ##1 o_running_out);
    c_trip: cover property (@(posedge i_clock) disable iff (i_rst)
        o_running_out ##1 o_fault_active ##1 !o_running_out);
    c_ack: cover property (@(posedge i_clock) disable iff (i_rst)
        o_fault_active ##1 !o_fault_active);

endmodule // dtc_command

// ### tb/dtc_switches.sv
// operator switch model: drives the eight terminal pins of the drive.
// assumes its tasks are called from one bench process, one at a time.
`timescale 1ns/100ps

module dtc_switches
(
    // clock
    input wire logic i_clock,
    // terminal pins towards the drive
    output logic [dtc_pkg::NUM_DI-1:0] o_pins
);
    logic [dtc_pkg::NUM_DI-1:0] pins_q;

    // estop loop closed from the start, as the fail-safe wiring needs
    initial pins_q = 8'h10;
    assign o_pins = pins_q;

    // switches change just after a clock edge and then hold
    task automatic set_pin(input int idx, input logic val);
        @(posedge i_clock);
        pins_q[idx] <= val;
    endtask

    // contact bounce: a blip shorter than the settling time
    task automatic bounce(input int idx, input int len);
        set_pin(idx, !pins_q[idx]);
        repeat (len) @(posedge i_clock);
        pins_q[idx] <= !pins_q[idx];
    endtask
endmodule // dtc_switches

// ### tb/tb_drive_terminal_command_logic.sv
// testbench of the terminal command logic, driven through switch model.
// assumes a short settling count so every pin change lands in a few edges.
`timescale 1ns/100ps

module tb_drive_terminal_command_logic;
    localparam int DEB = 4;
    localparam int LIMIT = 3000;
    localparam logic [15:0] REF1 = 16'h1234;
    localparam logic [15:0] REF2 = 16'h0777;
    localparam logic [15:0] J1 = 16'h0100;
    localparam logic [15:0] J2 = 16'h0200;
    localparam logic [15:0] ACC = 16'h0011;
    localparam logic [15:0] DEC = 16'h0022;
    localparam logic [15:0] JACC = 16'h0033;
    localparam logic [15:0] JDEC = 16'h0044;
    logic i_clock;
    logic i_rst;
    logic [7:0] pins;
    logic [15:0] ana1, ana2;
    logic signed [15:0] spd;
    dtc_pkg::dtc_cfg_t cfg;
    logic rdy, run_o, zero, grp, mc, cce, jog, flt, alm;
    logic [15:0] sref, acc, dec, tlim, aout;
    logic [2:0] rows [6] = '{3'b100, 3'b110, 3'b010, 3'b111, 3'b001, 3'b000};
    logic [15:0] spds [4] = '{16'h0010, 16'hffef, 16'hfff0, 16'h0011};
    logic [15:0] e_ref;
    logic e_jog;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;

    dtc_switches sw_u (.i_clock(i_clock), .o_pins(pins));

    dtc_command #(.DEB_CYCLES(DEB)) dut_u (
        .i_clock(i_clock), .i_rst(i_rst),
        .i_jog_one_in(pins[dtc_pkg::DI_JOG_ONE]),
        .i_jog_two_in(pins[dtc_pkg::DI_JOG_TWO]),
        .i_ext_fault_in(pins[dtc_pkg::DI_EXT_FAULT]),
        .i_ext_alarm_in(pins[dtc_pkg::DI_EXT_ALARM]),
        .i_estop_loop_in(pins[dtc_pkg::DI_ESTOP]),
        .i_fault_ack_in(pins[dtc_pkg::DI_FAULT_ACK]),
        .i_on_off_in(pins[dtc_pkg::DI_ON_OFF]),
        .i_run_in(pins[dtc_pkg::DI_RUN]),
        .i_speed_ref_analog(ana1), .i_torque_lim_analog(ana2),
        .i_speed_actual(spd), .i_cfg(cfg),
        .o_ready_for_run_out(rdy), .o_running_out(run_o),
        .o_zero_speed_out(zero), .o_group_fault_out(grp),
        .o_main_contactor_out(mc), .o_current_ctrl_en(cce),
        .o_speed_ref(sref), .o_accel_ramp(acc), .o_decel_ramp(dec),
        .o_torque_limit(tlim), .o_jog_active(jog), .o_fault_active(flt),
        .o_alarm_active(alm), .o_speed_actual_analog_out(aout)
    );

    // 10 MHz system clock
    initial
    begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end

    // cut a hang short: counts as a mismatch
    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles >= LIMIT)
        begin
            n_errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({15'h0000, got}, {15'h0000, exp});
    endtask

    // ready, running, controller enable and reference in one go
    task automatic chk_drive(input logic e_rdy, input logic e_run,
                             input logic [15:0] e_sref);
        chk_bit(rdy, e_rdy);
        chk_bit(run_o, e_run);
        chk_bit(cce, e_run);
        chk_word(sref, e_sref);
    endtask

    // filter delay is at most DEB+5 edges; sample away from the edge
    task automatic settle();
        repeat (DEB + 8) @(posedge i_clock);
        @(negedge i_clock);
    endtask

    // main sequence
    initial
    begin
        i_rst = 1'b1;
        ana1 = REF1;
        ana2 = REF2;
        spd = 16'sh0005;
        cfg = '{1'b0, 1'b0, J1, J2, ACC, DEC, JACC, JDEC, 16'h0010};
        repeat (2) @(posedge i_clock);
        i_rst <= 1'b0;
        @(negedge i_clock);
        chk_drive(1'b0, 1'b0, 16'h0000);
        chk_bit(mc, 1'b0);
        $display("test reset done");
        sw_u.set_pin(dtc_pkg::DI_ON_OFF, 1'b1);
        settle();
        chk_drive(1'b1, 1'b0, 16'h0000);
        chk_bit(mc, 1'b1);
        chk_bit(zero, 1'b1);
        chk_word(tlim, dtc_pkg::FULL_TORQUE);
        $display("test switch on done");
        foreach (rows[i])
        begin
            sw_u.set_pin(dtc_pkg::DI_JOG_ONE, rows[i][2]);
            sw_u.set_pin(dtc_pkg::DI_JOG_TWO, rows[i][1]);
            sw_u.set_pin(dtc_pkg::DI_RUN, rows[i][0]);
            settle();
            e_ref = rows[i][0] ? REF1 : rows[i][1] ? J2
                : rows[i][2] ? J1 : 16'h0000;
            e_jog = |rows[i][2:1] && !rows[i][0];
            chk_drive(!(|rows[i]), |rows[i], e_ref);
            chk_bit(jog, e_jog);
            chk_word(acc, e_jog ? JACC : ACC);
            chk_word(dec, e_jog ? JDEC : DEC);
        end
        $display("test interlock done");
        sw_u.set_pin(dtc_pkg::DI_RUN, 1'b1);
        sw_u.set_pin(dtc_pkg::DI_EXT_ALARM, 1'b1);
        settle();
        chk_bit(alm, 1'b1);
        chk_bit(run_o, 1'b1);
        chk_bit(grp, 1'b1);
        sw_u.set_pin(dtc_pkg::DI_EXT_ALARM, 1'b0);
        sw_u.bounce(dtc_pkg::DI_RUN, DEB - 2);
        settle();
        chk_bit(grp, 1'b0);
        chk_bit(run_o, 1'b1);
        $display("test alarm and bounce done");
        sw_u.set_pin(dtc_pkg::DI_ESTOP, 1'b0);
        settle();
        chk_drive(1'b0, 1'b0, 16'h0000);
        chk_bit(flt, 1'b0);
        sw_u.set_pin(dtc_pkg::DI_ESTOP, 1'b1);
        sw_u.set_pin(dtc_pkg::DI_EXT_FAULT, 1'b1);
        settle();
        chk_drive(1'b0, 1'b0, 16'h0000);
        chk_bit(flt, 1'b1);
        chk_bit(grp, 1'b1);
        sw_u.set_pin(dtc_pkg::DI_FAULT_ACK, 1'b1);
        settle();
        chk_bit(flt, 1'b1);
        sw_u.set_pin(dtc_pkg::DI_FAULT_ACK, 1'b0);
        sw_u.set_pin(dtc_pkg::DI_EXT_FAULT, 1'b0);
        sw_u.set_pin(dtc_pkg::DI_RUN, 1'b0);
        settle();
        chk_bit(flt, 1'b1);
        sw_u.set_pin(dtc_pkg::DI_FAULT_ACK, 1'b1);
        settle();
        chk_bit(flt, 1'b0);
        chk_bit(grp, 1'b0);
        chk_bit(rdy, 1'b1);
        sw_u.set_pin(dtc_pkg::DI_FAULT_ACK, 1'b0);
        $display("test estop and fault done");
        sw_u.set_pin(dtc_pkg::DI_RUN, 1'b1);
        sw_u.set_pin(dtc_pkg::DI_ON_OFF, 1'b0);
        settle();
        chk_drive(1'b0, 1'b0, 16'h0000);
        chk_bit(mc, 1'b0);
        $display("test off done");
        // configuration and speed change on the rising edge like the pins
        @(posedge i_clock);
        cfg.limited_speed_control <= 1'b1;
        foreach (spds[i])
        begin
            @(posedge i_clock);
            spd <= spds[i];
            settle();
            chk_bit(zero, i[0] ? 1'b0 : 1'b1);
            chk_word(aout, spds[i]);
        end
        chk_word(tlim, REF2);
        $display("test limit and speed done");
        @(posedge i_clock);
        cfg.hand_auto_sel <= 1'b1;
        sw_u.set_pin(dtc_pkg::DI_RUN, 1'b0);
        sw_u.set_pin(dtc_pkg::DI_ON_OFF, 1'b1);
        sw_u.set_pin(dtc_pkg::DI_JOG_ONE, 1'b1);
        settle();
        chk_drive(1'b0, 1'b1, REF1);
        sw_u.set_pin(dtc_pkg::DI_JOG_ONE, 1'b0);
        sw_u.set_pin(dtc_pkg::DI_JOG_TWO, 1'b1);
        sw_u.set_pin(dtc_pkg::DI_RUN, 1'b1);
        settle();
        chk_drive(1'b0, 1'b1, REF2);
        $display("test hand auto done");
        end_of_test();
    end
endmodule // tb_drive_terminal_command_logic
